// [verilog/axrag_agent.sv]
// RAM agent end: AXI4 subordinate with internal word memory
`timescale 1ns/1ns
`default_nettype none
module axrag_agent #(
    parameter int id_tag_width = axrag_pkg::DEF_ID_W,
    parameter int addr_bit_width = axrag_pkg::DEF_ADDR_W,
    parameter int data_bit_width = axrag_pkg::DEF_DATA_W
)(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reset_req,
    output logic mem_clk_en,
    axrag_if.agent bus
);
    // ------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------
    localparam int STRB_W = data_bit_width / 8; // Byte lanes
    localparam int LSB = $clog2(STRB_W); // Byte offset bits
    localparam int DEPTH = 1 << (addr_bit_width - LSB); // Words

    typedef enum logic [1:0] {AXRAG_W_IDLE, AXRAG_W_DATA, AXRAG_W_RESP} axrag_wst_t;
    typedef enum logic [1:0] {AXRAG_R_IDLE, AXRAG_R_DATA} axrag_rst_t;

    logic [data_bit_width-1:0] mem [DEPTH]; // Storage array
    axrag_wst_t wst_q; // Write state
    axrag_rst_t rst_q; // Read state
    logic [addr_bit_width-1:0] waddr_q; // Current write beat address
    logic [7:0] wlen_q; // Write length
    logic [2:0] wsize_q; // Write size
    logic [1:0] wburst_q; // Write burst type
    logic werr_q; // Write burst illegal
    logic [addr_bit_width-1:0] raddr_q; // Current read beat address
    logic [7:0] rlen_q; // Read length
    logic [7:0] rcnt_q; // Read beats left after current
    logic [2:0] rsize_q; // Read size
    logic [1:0] rburst_q; // Read burst type
    logic rerr_q; // Read burst illegal
    logic gate_q; // Memory clock enable
    logic aw_hs; // Write address handshake
    logic w_hs; // Write data handshake
    logic ar_hs; // Read address handshake
    logic r_hs; // Read data handshake
    logic [63:0] wnext; // Next write address, wide
    logic [63:0] rnext; // Next read address, wide

    // Burst type other than INCR or WRAP
    function automatic logic bad_burst(input logic [1:0] kind);
        return (kind != axrag_pkg::BURST_INCR) && (kind != axrag_pkg::BURST_WRAP);
    endfunction

    assign aw_hs = bus.awvalid & bus.awready;
    assign w_hs = bus.wvalid & bus.wready;
    assign ar_hs = bus.arvalid & bus.arready;
    assign r_hs = bus.rvalid & bus.rready;
    // R3 R7 write address step
    assign wnext = axrag_pkg::next_addr(64'(waddr_q), wlen_q, wsize_q, wburst_q);
    // R4 R8 read address step
    assign rnext = axrag_pkg::next_addr(64'(raddr_q), rlen_q, rsize_q, rburst_q);

    // ------------------------------------------------------------
    // Memory clock gating
    // ------------------------------------------------------------
    // R16 gate during reset
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            gate_q <= 1'b0;
        else
            gate_q <= ~reset_req;
    end
    assign mem_clk_en = gate_q;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Write state machine and handshakes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // R20 quiet in reset
            wst_q <= AXRAG_W_IDLE;
            {bus.awready, bus.wready, bus.bvalid, bus.bid} <= '0;
            bus.bresp <= axrag_pkg::RESP_OKAY;
            {waddr_q, wlen_q, wsize_q, wburst_q, werr_q} <= '0;
        end
        else
        begin
            unique case (wst_q)
                AXRAG_W_IDLE:
                begin
                    // R13 ready only when idle
                    bus.awready <= ~aw_hs & gate_q;
                    if (aw_hs)
                    begin
                        // R3 R11 capture first address and tag
                        waddr_q <= bus.awaddr;
                        wlen_q <= bus.awlen;
                        wsize_q <= bus.awsize;
                        wburst_q <= bus.awburst;
                        bus.bid <= bus.awid;
                        // R1 flag unsupported burst type
                        werr_q <= bad_burst(bus.awburst);
                        bus.wready <= 1'b1;
                        wst_q <= AXRAG_W_DATA;
                    end
                end
                AXRAG_W_DATA:
                begin
                    if (w_hs)
                    begin
                        waddr_q <= addr_bit_width'(wnext);
                        // R5 R10 burst ends on last beat
                        if (bus.wlast)
                        begin
                            bus.wready <= 1'b0;
                            bus.bvalid <= 1'b1;
                            // R19 okay for normal access
                            bus.bresp <= werr_q ? axrag_pkg::RESP_SLVERR : axrag_pkg::RESP_OKAY;
                            wst_q <= AXRAG_W_RESP;
                        end
                    end
                end
                AXRAG_W_RESP:
                begin
                    // R18 hold until ready
                    if (bus.bready)
                    begin
                        bus.bvalid <= 1'b0;
                        wst_q <= AXRAG_W_IDLE;
                    end
                end
                default:
                    wst_q <= AXRAG_W_IDLE;
            endcase
        end
    end

    // R9 strobed lanes only
    always_ff @(posedge core_clk)
    begin
        if (w_hs && !werr_q)
        begin
            for (int i = 0; i < STRB_W; i++)
            begin
                if (bus.wstrb[i])
                    mem[waddr_q[addr_bit_width-1:LSB]][i*8 +: 8] <= bus.wdata[i*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read state machine and data return
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // R20 quiet in reset
            rst_q <= AXRAG_R_IDLE;
            {bus.arready, bus.rvalid, bus.rlast, bus.rid, bus.rdata} <= '0;
            bus.rresp <= axrag_pkg::RESP_OKAY;
            {raddr_q, rlen_q, rcnt_q, rsize_q, rburst_q, rerr_q} <= '0;
        end
        else
        begin
            unique case (rst_q)
                AXRAG_R_IDLE:
                begin
                    // R14 ready only when idle
                    bus.arready <= ~ar_hs & gate_q;
                    if (ar_hs)
                    begin
                        // R4 R12 capture first address and tag
                        raddr_q <= bus.araddr;
                        rlen_q <= bus.arlen;
                        rsize_q <= bus.arsize;
                        rburst_q <= bus.arburst;
                        rcnt_q <= bus.arlen;
                        bus.rid <= bus.arid;
                        // R2 flag unsupported burst type
                        rerr_q <= bad_burst(bus.arburst);
                        bus.rvalid <= 1'b1;
                        bus.rdata <= mem[bus.araddr[addr_bit_width-1:LSB]];
                        // R6 R19 single beat is last
                        bus.rlast <= (bus.arlen == 8'h00);
                        bus.rresp <= bad_burst(bus.arburst) ? axrag_pkg::RESP_SLVERR : axrag_pkg::RESP_OKAY;
                        rst_q <= AXRAG_R_DATA;
                    end
                end
                AXRAG_R_DATA:
                begin
                    // R18 hold beat until ready
                    if (r_hs)
                    begin
                        if (bus.rlast)
                        begin
                            bus.rvalid <= 1'b0;
                            bus.rlast <= 1'b0;
                            rst_q <= AXRAG_R_IDLE;
                        end
                        else
                        begin
                            // R4 R6 next beat
                            raddr_q <= addr_bit_width'(rnext);
                            bus.rdata <= mem[rnext[addr_bit_width-1:LSB]];
                            rcnt_q <= rcnt_q - 8'h01;
                            // R19 mark final beat
                            bus.rlast <= (rcnt_q == 8'h01);
                            bus.rresp <= rerr_q ? axrag_pkg::RESP_SLVERR : axrag_pkg::RESP_OKAY;
                        end
                    end
                end
                default:
                    rst_q <= AXRAG_R_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [verilog/axrag_pkg.sv]
// Constants shared by the second-port RAM agent and its AXI host end
// Summary of operation
// R1 - Write bursts are INCR or WRAP only
// R2 - Read bursts are INCR or WRAP only
// R3 - Write beat addresses stepped from first address
// R4 - Read beat addresses stepped from first address
// R5 - Write length gives exact data beat count
// R6 - Read length gives returned beat count
// R7 - Write size sets write address step
// R8 - Read size sets read address step
// R9 - Only strobed write byte lanes stored
// R10 - Host marks final write beat as last
// R11 - Write response returns write address ID
// R12 - Read data returns read address ID
// R13 - Write address ready only when acceptable
// R14 - Read address ready only when acceptable
// R15 - Host drives valid, agent ready, per channel (code: on B and R channels agent drives bvalid/rvalid, host bready/rready)
// R16 - Reset request gates memory clock during reset
// R17 - Host holds valid until agent ready
// R18 - Agent holds valid until host ready
// R19 - Read last on final beat, OKAY response
// R20 - Ready and valid low during reset
package axrag_pkg;

    // ------------------------------------------------------------
    // Burst encodings
    // ------------------------------------------------------------
    localparam logic [1:0] BURST_FIXED = 2'h0; // Not supported
    localparam logic [1:0] BURST_INCR = 2'h1; // Incrementing
    localparam logic [1:0] BURST_WRAP = 2'h2; // Wrapping

    // ------------------------------------------------------------
    // Response codes and field widths
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0; // Normal access
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Bad burst type
    localparam int LEN_W = 8; // Length field width
    localparam int SIZE_W = 3; // Size field width
    localparam int BURST_W = 2; // Burst field width
    localparam int RESP_W = 2; // Response width

    // ------------------------------------------------------------
    // Default widths
    // ------------------------------------------------------------
    localparam int DEF_ID_W = 4; // Default id_tag_width
    localparam int DEF_ADDR_W = 12; // Default addr_bit_width
    localparam int DEF_DATA_W = 32; // Default data_bit_width

    // Next beat address for INCR or WRAP bursts
    function automatic logic [63:0] next_addr(
        input logic [63:0] addr,
        input logic [7:0] len,
        input logic [2:0] size,
        input logic [1:0] burst
    );
        logic [63:0] step;
        logic [63:0] span;
        logic [63:0] inc;
        step = 64'h1 << size;
        span = ({56'h0, len} + 64'h1) << size;
        inc = addr + step;
        if (burst == BURST_WRAP)
        begin
            // Wrap within the span-aligned window
            next_addr = (addr & ~(span - 64'h1)) | (inc & (span - 64'h1));
        end
        else
        begin
            // Aligned increment
            next_addr = inc & ~(step - 64'h1);
        end
    endfunction

endpackage

// [verilog/axrag_if.sv]
// AXI4 link between the host end and the RAM agent end
`timescale 1ns/1ns
`default_nettype none
interface axrag_if #(
    parameter int id_tag_width = axrag_pkg::DEF_ID_W,
    parameter int addr_bit_width = axrag_pkg::DEF_ADDR_W,
    parameter int data_bit_width = axrag_pkg::DEF_DATA_W
);
    // Write address channel
    logic [id_tag_width-1:0] awid;
    logic [addr_bit_width-1:0] awaddr;
    logic [7:0] awlen;
    logic [2:0] awsize;
    logic [1:0] awburst;
    logic awvalid;
    logic awready;
    // Write data channel
    logic [data_bit_width-1:0] wdata;
    logic [data_bit_width/8-1:0] wstrb;
    logic wlast;
    logic wvalid;
    logic wready;
    // Write response channel
    logic [id_tag_width-1:0] bid;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    // Read address channel
    logic [id_tag_width-1:0] arid;
    logic [addr_bit_width-1:0] araddr;
    logic [7:0] arlen;
    logic [2:0] arsize;
    logic [1:0] arburst;
    logic arvalid;
    logic arready;
    // Read data channel
    logic [id_tag_width-1:0] rid;
    logic [data_bit_width-1:0] rdata;
    logic [1:0] rresp;
    logic rlast;
    logic rvalid;
    logic rready;

    // Host drives request valid and payload and response ready, agent drives request ready and responses
    modport host (
        output awid, awaddr, awlen, awsize, awburst, awvalid, input awready,
        output wdata, wstrb, wlast, wvalid, input wready,
        input bid, bresp, bvalid, output bready,
        output arid, araddr, arlen, arsize, arburst, arvalid, input arready,
        input rid, rdata, rresp, rlast, rvalid, output rready
    );
    modport agent (
        input awid, awaddr, awlen, awsize, awburst, awvalid, output awready,
        input wdata, wstrb, wlast, wvalid, output wready,
        output bid, bresp, bvalid, input bready,
        input arid, araddr, arlen, arsize, arburst, arvalid, output arready,
        output rid, rdata, rresp, rlast, rvalid, input rready
    );
endinterface
`default_nettype wire

// [verilog/axrag_host.sv]
// Host end: issues one AXI4 burst per user command
`timescale 1ns/1ns
`default_nettype none
module axrag_host #(
    parameter int id_tag_width = axrag_pkg::DEF_ID_W,
    parameter int addr_bit_width = axrag_pkg::DEF_ADDR_W,
    parameter int data_bit_width = axrag_pkg::DEF_DATA_W
)(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [id_tag_width-1:0] cmd_id,
    input wire logic [addr_bit_width-1:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    input wire logic [2:0] cmd_size,
    input wire logic [1:0] cmd_burst,
    input wire logic [data_bit_width-1:0] wr_data,
    input wire logic [data_bit_width/8-1:0] wr_strb,
    output logic wr_take,
    output logic rd_valid,
    output logic [data_bit_width-1:0] rd_data,
    output logic rd_last,
    output logic done,
    output logic [1:0] done_resp,
    axrag_if.host bus
);
    typedef enum logic [2:0] {AXRAG_H_IDLE, AXRAG_H_AW, AXRAG_H_W, AXRAG_H_B, AXRAG_H_AR, AXRAG_H_R} axrag_hst_t;

    axrag_hst_t st_q; // Host state
    logic [7:0] left_q; // Write beats left after current

    // ------------------------------------------------------------
    // Host sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= AXRAG_H_IDLE;
            {left_q, cmd_ready, wr_take, rd_valid, rd_data, rd_last, done, done_resp} <= '0;
            {bus.awid, bus.awaddr, bus.awlen, bus.awsize, bus.awvalid, bus.bready} <= '0;
            {bus.wdata, bus.wstrb, bus.wlast, bus.wvalid} <= '0;
            {bus.arid, bus.araddr, bus.arlen, bus.arsize, bus.arvalid, bus.rready} <= '0;
            bus.awburst <= axrag_pkg::BURST_INCR;
            bus.arburst <= axrag_pkg::BURST_INCR;
        end
        else
        begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            done <= 1'b0;
            unique case (st_q)
                AXRAG_H_IDLE:
                begin
                    cmd_ready <= ~(cmd_valid & cmd_ready);
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'b0;
                        if (cmd_write)
                        begin
                            bus.awid <= cmd_id;
                            bus.awaddr <= cmd_addr;
                            bus.awlen <= cmd_len;
                            bus.awsize <= cmd_size;
                            // R1 R15 only INCR or WRAP issued
                            bus.awburst <= (cmd_burst == axrag_pkg::BURST_WRAP) ?
                                           axrag_pkg::BURST_WRAP : axrag_pkg::BURST_INCR;
                            bus.awvalid <= 1'b1;
                            left_q <= cmd_len;
                            st_q <= AXRAG_H_AW;
                        end
                        else
                        begin
                            bus.arid <= cmd_id;
                            bus.araddr <= cmd_addr;
                            bus.arlen <= cmd_len;
                            bus.arsize <= cmd_size;
                            // R2 only INCR or WRAP issued
                            bus.arburst <= (cmd_burst == axrag_pkg::BURST_WRAP) ?
                                           axrag_pkg::BURST_WRAP : axrag_pkg::BURST_INCR;
                            bus.arvalid <= 1'b1;
                            st_q <= AXRAG_H_AR;
                        end
                    end
                end
                AXRAG_H_AW:
                begin
                    // R17 hold address until ready
                    if (bus.awready)
                    begin
                        bus.awvalid <= 1'b0;
                        bus.wdata <= wr_data;
                        bus.wstrb <= wr_strb;
                        // R10 last on final beat
                        bus.wlast <= (left_q == 8'h00);
                        bus.wvalid <= 1'b1;
                        wr_take <= 1'b1;
                        st_q <= AXRAG_H_W;
                    end
                end
                AXRAG_H_W:
                begin
                    // R5 R17 exactly len plus one beats
                    if (bus.wready)
                    begin
                        if (bus.wlast)
                        begin
                            bus.wvalid <= 1'b0;
                            bus.wlast <= 1'b0;
                            bus.bready <= 1'b1;
                            st_q <= AXRAG_H_B;
                        end
                        else
                        begin
                            bus.wdata <= wr_data;
                            bus.wstrb <= wr_strb;
                            bus.wlast <= (left_q == 8'h01);
                            left_q <= left_q - 8'h01;
                            wr_take <= 1'b1;
                        end
                    end
                end
                AXRAG_H_B:
                begin
                    if (bus.bvalid)
                    begin
                        bus.bready <= 1'b0;
                        done <= 1'b1;
                        done_resp <= bus.bresp;
                        st_q <= AXRAG_H_IDLE;
                    end
                end
                AXRAG_H_AR:
                begin
                    // R17 hold address until ready
                    if (bus.arready)
                    begin
                        bus.arvalid <= 1'b0;
                        bus.rready <= 1'b1;
                        st_q <= AXRAG_H_R;
                    end
                end
                AXRAG_H_R:
                begin
                    if (bus.rvalid)
                    begin
                        rd_valid <= 1'b1;
                        rd_data <= bus.rdata;
                        rd_last <= bus.rlast;
                        if (bus.rlast)
                        begin
                            bus.rready <= 1'b0;
                            done <= 1'b1;
                            done_resp <= bus.rresp;
                            st_q <= AXRAG_H_IDLE;
                        end
                    end
                end
                default:
                    st_q <= AXRAG_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [verif/axrag_properties.sv]
// Link handshake checks between host end and RAM agent end
`timescale 1ns/1ns
`default_nettype none
module axrag_properties #(
    parameter int id_tag_width = 4
)(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [id_tag_width-1:0] awid,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic wlast,
    input wire logic [id_tag_width-1:0] bid,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [id_tag_width-1:0] arid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [id_tag_width-1:0] rid,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [id_tag_width-1:0] wid_q; // Tag of last write address
    logic [id_tag_width-1:0] rid_q; // Tag of last read address
    // Capture tags at address handshakes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wid_q <= '0;
            rid_q <= '0;
        end
        else
        begin
            if (awvalid && awready) wid_q <= awid;
            if (arvalid && arready) rid_q <= arid;
        end
    end
    aw_take_once_a: assert property (awvalid && awready |=> !awready && wready)
        else $error("aw follow-up wrong");
    ar_take_once_a: assert property (arvalid && arready |=> !arready && rvalid)
        else $error("ar follow-up wrong");
    write_end_a: assert property (wvalid && wready && wlast |=> bvalid && !wready)
        else $error("no response after wlast");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bid))
        else $error("bvalid dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rid))
        else $error("rvalid dropped");
    b_tag_a: assert property (bvalid |-> bid == wid_q && bresp == 2'h0)
        else $error("bad bid or bresp");
    r_tag_a: assert property (rvalid |-> rid == rid_q && rresp == 2'h0)
        else $error("bad rid or rresp");
    reset_quiet_a: assert property (disable iff (1'b0) !arst_n |-> !(awready || arready || wready || bvalid || rvalid))
        else $error("ready/valid in reset");
endmodule
`default_nettype wire

// [verif/test_axi_second_port_ram_agent.sv]
// Random write-then-read bursts from host end into RAM agent end
`timescale 1ns/1ns
`default_nettype none
module test_axi_second_port_ram_agent;
    logic core_clk, arst_n, reset_req, mem_clk_en; // Clock, reset, gating
    logic cmd_valid, cmd_ready, cmd_write, wr_take, rd_valid, rd_last, done; // Host user side
    logic [3:0] cmd_id, wr_strb; // Tag, byte enables
    logic [11:0] cmd_addr, a; // Start address
    logic [7:0] cmd_len, ln; // Beats minus one
    logic [2:0] cmd_size, s; // Log2 beat bytes
    logic [1:0] cmd_burst, done_resp, b; // Burst code, result
    logic [31:0] wr_data, rd_data; // Beat data
    logic [7:0] mem [int]; // Byte model
    logic [31:0] wd [256]; // Beat data
    logic [3:0] ws [256]; // Beat strobes
    int n_mismatch = 0, cmp_count = 0, cyc = 0, k = 0; // Counters
    axrag_if bus_if ();
    axrag_agent axrag_agent_inst (.core_clk(core_clk), .arst_n(arst_n), .reset_req(reset_req),
        .mem_clk_en(mem_clk_en), .bus(bus_if));
    axrag_host axrag_host_inst (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size),
        .cmd_burst(cmd_burst), .wr_data(wr_data), .wr_strb(wr_strb), .wr_take(wr_take), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_last(rd_last), .done(done), .done_resp(done_resp), .bus(bus_if));
    axrag_properties axrag_properties_inst (.core_clk(core_clk), .arst_n(arst_n), .awid(bus_if.awid),
        .awvalid(bus_if.awvalid), .awready(bus_if.awready), .wvalid(bus_if.wvalid), .wready(bus_if.wready),
        .wlast(bus_if.wlast), .bid(bus_if.bid), .bresp(bus_if.bresp), .bvalid(bus_if.bvalid), .bready(bus_if.bready),
        .arid(bus_if.arid), .arvalid(bus_if.arvalid), .arready(bus_if.arready), .rid(bus_if.rid),
        .rresp(bus_if.rresp), .rvalid(bus_if.rvalid), .rready(bus_if.rready));
    // Verdict and end of run
    task automatic complete_run();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Count and report one compare
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    // Expected next beat address
    function automatic logic [11:0] step_addr(input logic [11:0] x, input int len, input int sz, input bit wrap);
        logic [11:0] w;
        w = 12'((len + 1) << sz);
        if (wrap) return (x & ~(w - 12'h1)) | ((x + (12'h1 << sz)) & (w - 12'h1));
        return (x + (12'h1 << sz)) & ~((12'h1 << sz) - 12'h1);
    endfunction
    // One burst: issue, feed beats, model or compare
    task automatic burst(input logic wr, input logic [11:0] a0, input logic [7:0] len);
        int beat;
        logic [11:0] x;
        x = a0;
        beat = 0;
        for (int i = 0; i < 256; i++) {wd[i], ws[i]} = {$urandom, 4'($urandom)};
        k = 0;
        {wr_data, wr_strb} <= {wd[0], ws[0]};
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_id <= 4'($urandom);
        cmd_addr <= a0;
        cmd_len <= len;
        cmd_size <= s;
        cmd_burst <= b;
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (int t = 0; t < 600 && done !== 1'b1; t++)
        begin
            @(posedge core_clk);
            if (wr && wr_take === 1'b1)
            begin
                for (int i = 0; i < 4; i++) if (ws[beat][i]) mem[(x & ~12'h3) + i] = wd[beat][8*i+:8];
                x = step_addr(x, len, s, b == 2'h2);
                beat++;
            end
            if (!wr && rd_valid === 1'b1)
            begin
                for (int i = 0; i < 4; i++) if (mem.exists((x & ~12'h3) + i)) check(rd_data[8*i+:8] === mem[(x & ~12'h3) + i], "read byte");
                check(rd_last === (beat == len), "last flag");
                x = step_addr(x, len, s, b == 2'h2);
                beat++;
            end
        end
        check(done === 1'b1 && done_resp === 2'h0 && beat == len + 1, "burst end");
    endtask
    // Clock and next write beat on each taken beat, plus hang limit
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        // Host loads a beat at this edge: present the next one
        if ((bus_if.awvalid && bus_if.awready) || (bus_if.wvalid && bus_if.wready && !bus_if.wlast))
        begin
            k = k + 1;
            {wr_data, wr_strb} <= {wd[k[7:0]], ws[k[7:0]]};
        end
        if (cyc == 60000)
        begin
            n_mismatch++;
            complete_run();
        end
    end
    // Main sequence
    initial
    begin
        {arst_n, reset_req, cmd_valid, cmd_write, cmd_id, cmd_addr, cmd_len, cmd_size, cmd_burst} = '0;
        {wr_data, wr_strb} = '0;
        void'($urandom(32'hD04D9964));
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        reset_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(mem_clk_en === 1'b0 && bus_if.awready === 1'b0, "gating");
        reset_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(mem_clk_en === 1'b1, "gating end");
        s = 3'h2;
        b = 2'h1;
        burst(1'b1, 12'h000, 8'hFF);
        burst(1'b0, 12'h000, 8'hFF);
        for (int n = 0; n < 60; n++)
        begin
            s = 3'($urandom_range(2));
            b = 2'($urandom);
            ln = (b == 2'h2) ? 8'((2 << $urandom_range(3)) - 1) : 8'($urandom_range(15));
            a = 12'($urandom_range(2047)) & ~((12'h1 << s) - 12'h1);
            burst(1'b1, a, ln);
            burst(1'b0, a, ln);
        end
        complete_run();
    end
endmodule
`default_nettype wire
